// ---- verilog/afecfg_bank.sv ----
// Purpose: per-slot signal path configuration register bank
// Assumes: host register port and pulse inputs are on ref_clk
// Notes:   decoded settings are registered one cycle after a write
`default_nettype none

module afecfg_bank (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // host register port
  input  wire afecfg_pkg::afecfg_reg_req_t  reg_req,
  output logic [afecfg_pkg::DATA_W-1:0]     reg_rdata,
  output logic                              reg_rvalid,
  // timing pulses from the slot sequencer
  input  wire logic                         led_pulse_a,
  input  wire logic                         led_pulse_b,
  input  wire logic                         conv_start_a,
  input  wire logic                         conv_start_b,
  // decoded slot settings
  output afecfg_pkg::afecfg_slot_cfg_t      slot_a_cfg,
  output afecfg_pkg::afecfg_slot_cfg_t      slot_b_cfg,
  // receive path switches
  output logic                              pd_connect_a,
  output logic                              pd_connect_b,
  output logic                              led_drive_a,
  output logic                              led_drive_b,
  // channel sampling
  output logic                              sample_stb,
  output logic [1:0]                        sample_chan,
  output logic                              sample_slot_b
);
  import afecfg_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] ctrl_a_ff, nxt_ctrl_a;     // slot A path control
  logic [15:0] conn_a_ff, nxt_conn_a;     // slot A path connection
  logic [15:0] ctrl_b_ff, nxt_ctrl_b;     // slot B path control
  logic [15:0] conn_b_ff, nxt_conn_b;     // slot B path connection
  logic [15:0] glob_ff,   nxt_glob;       // global buffer enable
  logic [15:0] led_ff,    nxt_led;        // LED select
  logic [15:0] rdata_ff,  nxt_rdata;      // read answer
  logic        rvalid_ff, nxt_rvalid;

  afecfg_slot_cfg_t cfg_a_ff, nxt_cfg_a;  // decoded slot A
  afecfg_slot_cfg_t cfg_b_ff, nxt_cfg_b;  // decoded slot B
  logic pdc_a_ff, nxt_pdc_a, pdc_b_ff, nxt_pdc_b;
  logic led_a_ff, nxt_led_a, led_b_ff, nxt_led_b;
  logic slot_b_ff, nxt_slot_b;            // slot of running sequence
  logic seq_busy;
  logic seq_start;

  // ---------------------------------------------------------------
  // decode of one slot
  // ---------------------------------------------------------------
  function automatic afecfg_slot_cfg_t decode_slot(
    input logic [15:0] ctrl,
    input logic [15:0] conn,
    input logic        glob_en,
    input logic [1:0]  led_sel
  );
    afecfg_slot_cfg_t c;
    c = '0;
    case (conn)
      CONN_NORMAL:      c.path = PATH_NORMAL;
      CONN_BPF_BYPASS:  c.path = PATH_BPF_BYPASS;
      CONN_FULL_BYPASS: c.path = PATH_FULL_BYPASS;
      default:          c.path = PATH_UNDEFINED;
    endcase
    // normal routing with no LED means the input is pulsed instead
    if (c.path == PATH_NORMAL && led_sel == 2'h0) begin
      c.path = PATH_PULSE_CONNECT;
    end
    c.integrator_setup  = ctrl[SETUP_LSB +: SETUP_W];
    c.buffer_gain_sel   = ctrl[GAIN_BIT];
    // the slot bit alone does nothing until the global bit is set
    c.integrator_buffer = ctrl[INTBUF_BIT] & glob_en;
    c.bias_reference    = ctrl[BIAS_LSB +: BIAS_W];
    c.tia_adc_mode      = (c.path == PATH_BPF_BYPASS) ||
                          (c.path == PATH_FULL_BYPASS);
    c.setup_fault       = (conn == CONN_BPF_BYPASS) &&
                          !c.integrator_buffer;
    return c;
  endfunction

  // ---------------------------------------------------------------
  // register writes; whole words are kept so untouched bits survive
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_conn_a = conn_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    nxt_conn_b = conn_b_ff;
    nxt_glob   = glob_ff;
    nxt_led    = led_ff;
    if (reg_req.wr_en) begin
      case (reg_req.addr)
        OFS_SLOT_A_PATH_CTRL: nxt_ctrl_a = reg_req.wdata;
        OFS_SLOT_A_PATH_CONN: nxt_conn_a = reg_req.wdata;
        OFS_SLOT_B_PATH_CTRL: nxt_ctrl_b = reg_req.wdata;
        OFS_SLOT_B_PATH_CONN: nxt_conn_b = reg_req.wdata;
        OFS_BUF_GLOBAL_EN:    nxt_glob   = reg_req.wdata;
        OFS_LED_SELECT:       nxt_led    = reg_req.wdata;
        default: ;                           // unmapped: ignored
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads, answered one cycle after rd_en
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rvalid = reg_req.rd_en;
    nxt_rdata  = rdata_ff;
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        OFS_SLOT_A_PATH_CTRL: nxt_rdata = ctrl_a_ff;
        OFS_SLOT_A_PATH_CONN: nxt_rdata = conn_a_ff;
        OFS_SLOT_B_PATH_CTRL: nxt_rdata = ctrl_b_ff;
        OFS_SLOT_B_PATH_CONN: nxt_rdata = conn_b_ff;
        OFS_BUF_GLOBAL_EN:    nxt_rdata = glob_ff;
        OFS_LED_SELECT:       nxt_rdata = led_ff;
        default:              nxt_rdata = RD_UNMAPPED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // decode and path switches
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cfg_a = decode_slot(ctrl_a_ff, conn_a_ff, glob_ff[GLOBAL_BIT],
                            led_ff[LED_A_LSB +: LED_W]);
    nxt_cfg_b = decode_slot(ctrl_b_ff, conn_b_ff, glob_ff[GLOBAL_BIT],
                            led_ff[LED_B_LSB +: LED_W]);
    // pulse connect gates the input with the LED timing instead
    if (nxt_cfg_a.path == PATH_PULSE_CONNECT) begin
      nxt_pdc_a = led_pulse_a;
      nxt_led_a = 1'b0;
    end else begin
      nxt_pdc_a = 1'b1;
      nxt_led_a = led_pulse_a;
    end
    if (nxt_cfg_b.path == PATH_PULSE_CONNECT) begin
      nxt_pdc_b = led_pulse_b;
      nxt_led_b = 1'b0;
    end else begin
      nxt_pdc_b = 1'b1;
      nxt_led_b = led_pulse_b;
    end
  end

  // ---------------------------------------------------------------
  // channel sequence start; slot A wins a same-cycle request
  // ---------------------------------------------------------------
  always_comb begin
    nxt_slot_b = slot_b_ff;
    seq_start  = 1'b0;
    if (!seq_busy) begin
      if (conv_start_a && cfg_a_ff.tia_adc_mode) begin
        seq_start  = 1'b1;
        nxt_slot_b = 1'b0;
      end else if (conv_start_b && cfg_b_ff.tia_adc_mode) begin
        seq_start  = 1'b1;
        nxt_slot_b = 1'b1;
      end
    end
  end

  afecfg_chan_seq u_seq (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .start       (seq_start),
    .sample_stb  (sample_stb),
    .sample_chan (sample_chan),
    .busy        (seq_busy)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_a_ff <= RST_PATH_CTRL;
      conn_a_ff <= RST_PATH_CONN;
      ctrl_b_ff <= RST_PATH_CTRL;
      conn_b_ff <= RST_PATH_CONN;
      glob_ff   <= RST_GLOBAL;
      led_ff    <= RST_LED_SELECT;
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
      cfg_a_ff  <= '0;
      cfg_b_ff  <= '0;
      pdc_a_ff  <= 1'b1;
      pdc_b_ff  <= 1'b1;
      led_a_ff  <= 1'b0;
      led_b_ff  <= 1'b0;
      slot_b_ff <= 1'b0;
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
      conn_a_ff <= nxt_conn_a;
      ctrl_b_ff <= nxt_ctrl_b;
      conn_b_ff <= nxt_conn_b;
      glob_ff   <= nxt_glob;
      led_ff    <= nxt_led;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      cfg_a_ff  <= nxt_cfg_a;
      cfg_b_ff  <= nxt_cfg_b;
      pdc_a_ff  <= nxt_pdc_a;
      pdc_b_ff  <= nxt_pdc_b;
      led_a_ff  <= nxt_led_a;
      led_b_ff  <= nxt_led_b;
      slot_b_ff <= nxt_slot_b;
    end
  end

  assign reg_rdata     = rdata_ff;
  assign reg_rvalid    = rvalid_ff;
  assign slot_a_cfg    = cfg_a_ff;
  assign slot_b_cfg    = cfg_b_ff;
  assign pd_connect_a  = pdc_a_ff;
  assign pd_connect_b  = pdc_b_ff;
  assign led_drive_a   = led_a_ff;
  assign led_drive_b   = led_b_ff;
  assign sample_slot_b = slot_b_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_conn_a_bypass: assert property (
    conn_a_ff == CONN_FULL_BYPASS |=> slot_a_cfg.path == PATH_FULL_BYPASS)
    else $error("slot A full bypass not decoded");

  chk_conn_b_bypass: assert property (
    conn_b_ff == CONN_BPF_BYPASS |=>
    slot_b_cfg.path == PATH_BPF_BYPASS && slot_b_cfg.tia_adc_mode)
    else $error("slot B filter bypass not decoded");

  chk_gain_follows: assert property (
    reg_req.wr_en && reg_req.addr == OFS_SLOT_A_PATH_CTRL |-> ##2
    slot_a_cfg.buffer_gain_sel == $past(reg_req.wdata[GAIN_BIT], 2))
    else $error("buffer gain does not follow write");

  chk_buf_gated: assert property (
    slot_a_cfg.integrator_buffer || slot_b_cfg.integrator_buffer |->
    $past(glob_ff[GLOBAL_BIT]))
    else $error("integrator buffer without global enable");

  chk_setup_fault: assert property (
    conn_a_ff == CONN_BPF_BYPASS && !ctrl_a_ff[INTBUF_BIT] |=>
    slot_a_cfg.setup_fault)
    else $error("missing buffer bit not flagged");

  chk_bias_sel: assert property (
    ##1 slot_b_cfg.bias_reference == $past(ctrl_b_ff[5:4]))
    else $error("bias reference mismatch");

  chk_pulse_conn: assert property (
    cfg_a_ff.path == PATH_PULSE_CONNECT && nxt_cfg_a.path ==
    PATH_PULSE_CONNECT |=> pd_connect_a == $past(led_pulse_a) &&
    !led_drive_a)
    else $error("pulse connect not gating photodiode");

  chk_slot_indep: assert property (
    reg_req.wr_en && reg_req.addr == OFS_SLOT_A_PATH_CONN |=>
    $stable(conn_b_ff) && $stable(ctrl_b_ff))
    else $error("slot A write disturbed slot B");

  chk_bits_kept: assert property (
    !reg_req.wr_en |=> $stable(ctrl_a_ff) && $stable(glob_ff))
    else $error("register changed without write");

endmodule

`default_nettype wire

// ---- verilog/afecfg_pkg.sv ----
// Purpose: shared constants and types of the signal path mode config bank
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   register offsets are word indices on the host register port
//
// Overview of operation
// - slot A connection codes select path routing
// - slot B connection codes select path routing
// - control bit 9 selects buffer gain
// - bit 7 makes integrator a buffer
// - global bit 7 gates integrator buffer option
// - bits 5:4 select amplifier bias reference
// - pulse connect pulses photodiode, not LED
// - TRANSIMPEDANCE_STAGE ADC samples four channels 1us apart
// - slots are configured independently
`default_nettype none

package afecfg_pkg;

  // ---------------------------------------------------------------
  // register port geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;              // word index width
  localparam int DATA_W = 16;             // register width

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LED_SELECT        = 8'h14;
  localparam logic [7:0] OFS_SLOT_A_PATH_CTRL  = 8'h42;
  localparam logic [7:0] OFS_SLOT_A_PATH_CONN  = 8'h43;
  localparam logic [7:0] OFS_SLOT_B_PATH_CTRL  = 8'h44;
  localparam logic [7:0] OFS_SLOT_B_PATH_CONN  = 8'h45;
  localparam logic [7:0] OFS_BUF_GLOBAL_EN     = 8'h58;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SETUP_LSB    = 10;       // integrator setup [15:10]
  localparam int SETUP_W      = 6;
  localparam int GAIN_BIT     = 9;        // buffer gain select
  localparam int INTBUF_BIT   = 7;        // integrator as buffer
  localparam int BIAS_LSB     = 4;        // bias reference [5:4]
  localparam int BIAS_W       = 2;
  localparam int GLOBAL_BIT   = 7;        // global buffer enable
  localparam int LED_A_LSB    = 0;        // slot A LED select [1:0]
  localparam int LED_B_LSB    = 2;        // slot B LED select [3:2]
  localparam int LED_W        = 2;

  // ---------------------------------------------------------------
  // connection codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CONN_NORMAL      = 16'hada5;
  localparam logic [15:0] CONN_BPF_BYPASS  = 16'hae65;
  localparam logic [15:0] CONN_FULL_BYPASS = 16'hb065;

  // ---------------------------------------------------------------
  // reset values (normal pulsed mode)
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_PATH_CTRL  = 16'h1c00;
  localparam logic [15:0] RST_PATH_CONN  = 16'hada5;
  localparam logic [15:0] RST_GLOBAL     = 16'h0000;
  localparam logic [15:0] RST_LED_SELECT = 16'h0005;
  localparam logic [15:0] RD_UNMAPPED    = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CH_SPACING_NS  = 1000;   // gap between channel samples
  localparam int CH_SPACING_CYC =
    (CH_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_CH         = 4;
  localparam logic [1:0] LAST_CH = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // routing of the receive path
  typedef enum logic [2:0] {
    PATH_NORMAL,
    PATH_BPF_BYPASS,
    PATH_FULL_BYPASS,
    PATH_PULSE_CONNECT,
    PATH_UNDEFINED
  } afecfg_path_t;

  // decoded per-slot settings handed to the analog path
  typedef struct packed {
    afecfg_path_t       path;
    logic [SETUP_W-1:0] integrator_setup;
    logic               buffer_gain_sel;     // 1: gain 0.7
    logic               integrator_buffer;   // effective, gated
    logic [BIAS_W-1:0]  bias_reference;
    logic               tia_adc_mode;
    logic               setup_fault;         // filter bypass without gated buffer
  } afecfg_slot_cfg_t;

  // one host register access
  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afecfg_reg_req_t;

endpackage

`default_nettype wire

// ---- verilog/afecfg_chan_seq.sv ----
// Purpose: steps the converter over four channels in TRANSIMPEDANCE_STAGE ADC mode
// Assumes: start is a one-cycle pulse from logic on ref_clk
// Notes:   a start while busy is ignored
`default_nettype none

module afecfg_chan_seq (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       start,
  // sample strobes
  output logic            sample_stb,
  output logic [1:0]      sample_chan,
  output logic            busy
);
  import afecfg_pkg::*;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} afecfg_seq_state_t;

  afecfg_seq_state_t state_ff, nxt_state;   // sequencer state
  logic [7:0]        cnt_ff, nxt_cnt;       // cycles to next sample
  logic [1:0]        chan_ff, nxt_chan;     // channel of last sample
  logic              stb_ff, nxt_stb;       // sample strobe

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_chan  = chan_ff;
    nxt_stb   = 1'b0;
    case (state_ff)
      SEQ_IDLE: begin
        if (start) begin                   // first channel at once
          nxt_state = SEQ_RUN;
          nxt_chan  = 2'h0;
          nxt_stb   = 1'b1;
          nxt_cnt   = 8'(CH_SPACING_CYC - 1);
        end
      end
      SEQ_RUN: begin
        if (cnt_ff != 8'h00) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else if (chan_ff == LAST_CH) begin
          nxt_state = SEQ_IDLE;            // all four taken
        end else begin                     // next channel 1us on
          nxt_chan = chan_ff + 2'h1;
          nxt_stb  = 1'b1;
          nxt_cnt  = 8'(CH_SPACING_CYC - 1);
        end
      end
      default: nxt_state = SEQ_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= SEQ_IDLE;
      cnt_ff   <= 8'h00;
      chan_ff  <= 2'h0;
      stb_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      chan_ff  <= nxt_chan;
      stb_ff   <= nxt_stb;
    end
  end

  assign sample_stb  = stb_ff;
  assign sample_chan = chan_ff;
  assign busy        = (state_ff == SEQ_RUN);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_four_samples;
    sample_stb && sample_chan == 2'h0 ##100
    sample_stb && sample_chan == 2'h1 ##100
    sample_stb && sample_chan == 2'h2 ##100
    sample_stb && sample_chan == 2'h3;
  endsequence

  chk_chan_spacing: assert property (
    start && !busy |=> s_four_samples)
    else $error("channel samples not 1us apart");

  chk_strobe_gap: assert property (
    sample_stb |=> !sample_stb [*8])
    else $error("channel strobes too close");

endmodule

`default_nettype wire

// ---- testbench/afecfg_host_model.sv ----
// Purpose: host processor model on the register port of the bank
// Assumes: requests launch 1 ns after a rising edge of ref_clk
// Notes:   one request per call, an idle cycle between calls
`default_nettype none

module afecfg_host_model (
  // clock
  input  wire logic                        ref_clk,
  // register port
  output var  afecfg_pkg::afecfg_reg_req_t reg_req
);
  import afecfg_pkg::*;

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial reg_req = '0;  // idle port from time zero

  // request held until the taking edge has passed, then dropped
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    reg_req = '0;
  endtask

  // whole 16-bit words only, the port has no byte enables
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask

  // read answer is picked up by the bench monitor
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 16'h0000);
  endtask
endmodule

`default_nettype wire

// ---- testbench/afecfg_bank_tb.sv ----
// Purpose: self-checking bench for the signal path config bank
// Assumes: host model drives the register port, bench drives pulses
// Notes:   expected reads and samples queue up for a watching monitor
`default_nettype none

module afecfg_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import afecfg_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic             ref_clk;       // 100 MHz
  logic             reset_n;       // active-low reset
  afecfg_reg_req_t  reg_req;       // from host model
  logic [15:0]      reg_rdata;     // read answer
  logic             reg_rvalid;    // read strobe
  logic             led_pulse_a, led_pulse_b;
  logic             conv_start_a, conv_start_b;
  afecfg_slot_cfg_t slot_a_cfg, slot_b_cfg;
  logic             pd_connect_a, pd_connect_b;
  logic             led_drive_a, led_drive_b;
  logic             sample_stb;    // channel strobe
  logic [1:0]       sample_chan;
  logic             sample_slot_b;
  int               cyc;           // cycle count, also the timeout
  int               bad_count;
  int               tests_run;
  logic [15:0]      rd_q[$];       // expected read data
  logic [2:0]       smp_q[$];      // expected slot and channel
  int               smp_cyc_q[$];  // expected strobe cycle
  logic [15:0]      ctrl;          // control word under test
  logic [15:0]      v;             // random register value

  localparam logic [23:0] REG_TAB [7] = '{24'h421c00, 24'h43ada5,
    24'h441c00, 24'h45ada5, 24'h580000, 24'h140005, 24'h990000};
  localparam logic [15:0] CODES [4] = '{CONN_NORMAL, CONN_BPF_BYPASS,
    CONN_FULL_BYPASS, 16'h1234};

  // ---------------------------------------------------------------
  // clock, cycle count and hang guard
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // whole run needs about 1300 cycles, so 20000 is a safe ceiling
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  afecfg_host_model host_u (.ref_clk(ref_clk), .reg_req(reg_req));

  afecfg_bank dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .led_pulse_a(led_pulse_a), .led_pulse_b(led_pulse_b),
    .conv_start_a(conv_start_a), .conv_start_b(conv_start_b),
    .slot_a_cfg(slot_a_cfg), .slot_b_cfg(slot_b_cfg),
    .pd_connect_a(pd_connect_a), .pd_connect_b(pd_connect_b),
    .led_drive_a(led_drive_a), .led_drive_b(led_drive_b),
    .sample_stb(sample_stb), .sample_chan(sample_chan),
    .sample_slot_b(sample_slot_b)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    host_u.rd(a);
  endtask

  // decoded settings land one edge after the write edge
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  function automatic afecfg_path_t exp_path(input logic [15:0] c);
    case (c)
      CONN_NORMAL:      return PATH_NORMAL;
      CONN_BPF_BYPASS:  return PATH_BPF_BYPASS;
      CONN_FULL_BYPASS: return PATH_FULL_BYPASS;
      default:          return PATH_UNDEFINED;  // never tia adc
    endcase
  endfunction

  task automatic cfg_case(input logic b, input logic [15:0] cn,
                          input logic [15:0] ct, input logic g);
    afecfg_slot_cfg_t c;
    logic             eb;
    host_u.wr(b ? OFS_SLOT_B_PATH_CONN : OFS_SLOT_A_PATH_CONN, cn);
    host_u.wr(b ? OFS_SLOT_B_PATH_CTRL : OFS_SLOT_A_PATH_CTRL, ct);
    host_u.wr(OFS_BUF_GLOBAL_EN, {8'h00, g, 7'h00});
    settle();
    c = b ? slot_b_cfg : slot_a_cfg;
    eb = ct[7] & g;
    chk(c.path, exp_path(cn));
    chk(c.tia_adc_mode, cn == CONN_BPF_BYPASS || cn == CONN_FULL_BYPASS);
    chk(c.buffer_gain_sel, ct[9]);
    chk(c.integrator_buffer, eb);
    chk(c.setup_fault, cn == CONN_BPF_BYPASS && !eb);
    chk(c.bias_reference, ct[5:4]);
    chk(c.integrator_setup, ct[15:10]);
  endtask

  task automatic pulse(input logic p);
    @(posedge ref_clk);
    #1;
    led_pulse_a = p;
    led_pulse_b = p;
    settle();
  endtask

  // a start that is taken yields four strobes 100 cycles apart; the
  // sequencer then waits one more spacing, so it stays busy 400 cycles
  task automatic start(input logic a, input logic b, input logic acc);
    @(posedge ref_clk);
    #1;
    conv_start_a = a;
    conv_start_b = b;
    for (int i = 0; acc && i < NUM_CH; i++) begin
      smp_q.push_back({!a, 2'(i)});
      smp_cyc_q.push_back(cyc + 1 + i * CH_SPACING_CYC);
    end
    settle();
    conv_start_a = 1'b0;
    conv_start_b = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // monitor: oldest note against each result that appears
  // ---------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1)
      chk(reg_rdata, rd_q.size() ? rd_q.pop_front() : 'x);
    if (sample_stb === 1'b1) begin
      chk({sample_slot_b, sample_chan},
          smp_q.size() ? smp_q.pop_front() : 'x);
      chk(cyc, smp_cyc_q.size() ? smp_cyc_q.pop_front() : -1);
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    led_pulse_a = 1'b0;
    led_pulse_b = 1'b0;
    conv_start_a = 1'b0;
    conv_start_b = 1'b0;
    void'($urandom(17609));
    repeat (6) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    // reset values, an unmapped place reads zero
    foreach (REG_TAB[i]) rd_exp(REG_TAB[i][23:16], REG_TAB[i][15:0]);
    // random words are stored whole, unmapped writes vanish
    foreach (REG_TAB[i]) begin
      v = 16'($urandom);
      host_u.wr(REG_TAB[i][23:16], v);
      rd_exp(REG_TAB[i][23:16], i == 6 ? 16'h0000 : v);
    end
    host_u.wr(OFS_LED_SELECT, RST_LED_SELECT);
    // every code, every bias, buffer option with and without enable
    for (int k = 0; k < 8; k++) begin
      // buffer bit left clear on the filter-bypass code of both slots
      ctrl = {6'h07, 1'($urandom), 1'b0, ~k[0], 1'b0, 2'(k), 4'h0};
      cfg_case(k[2], CODES[k[1:0]], ctrl, k[2]);
    end
    // pulse connect on slot A, slot B stays in normal pulsed mode
    host_u.wr(OFS_SLOT_A_PATH_CONN, CONN_NORMAL);
    host_u.wr(OFS_SLOT_B_PATH_CONN, CONN_NORMAL);
    host_u.wr(OFS_LED_SELECT, 16'h0004);
    settle();
    chk(slot_a_cfg.path, PATH_PULSE_CONNECT);
    chk(slot_b_cfg.path, PATH_NORMAL);
    pulse(1'b1);
    chk({pd_connect_a, led_drive_a}, 2'b10);
    chk({pd_connect_b, led_drive_b}, 2'b11);
    pulse(1'b0);
    chk({pd_connect_a, led_drive_a}, 2'b00);
    chk({pd_connect_b, led_drive_b}, 2'b10);
    host_u.wr(OFS_LED_SELECT, RST_LED_SELECT);
    // four-channel sampling, refused starts leave no strobe
    cfg_case(1'b0, CONN_FULL_BYPASS, 16'h1c30, 1'b0);
    cfg_case(1'b1, CONN_NORMAL, 16'h1c00, 1'b0);
    start(1'b1, 1'b0, 1'b1);
    repeat (50) @(posedge ref_clk);
    start(1'b1, 1'b1, 1'b0);
    // sequencer idle again here, so this start is refused for mode only
    repeat (360) @(posedge ref_clk);
    start(1'b0, 1'b1, 1'b0);
    cfg_case(1'b1, CONN_BPF_BYPASS, 16'h1c80, 1'b1);
    start(1'b0, 1'b1, 1'b1);
    repeat (410) @(posedge ref_clk);
    start(1'b1, 1'b1, 1'b1);
    repeat (310) @(posedge ref_clk);
    chk(rd_q.size(), 0);
    chk(smp_q.size(), 0);
    end_of_test();
  end
endmodule

`default_nettype wire
